// *** logic/tw_unit.sv ***
`timescale 1ns/1ps
`include "tw_map.svh"
module tw_unit
	import tw_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic [31:0] hrdata_out,
	output logic hresp_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	output logic irq_out
);
	typedef enum logic [2:0] {
		st_idle, st_start, st_hold, st_low, st_high, st_edge, st_sl_bit
	} tw_state_t;
	function automatic logic [15:0] tw_half(input logic [7:0] r, input logic [1:0] p);
		tw_half = (16'(r) + 16'h1) << {p, 1'b0};
	endfunction : tw_half
	tw_req_t req;
	tw_line_t line;
	tw_state_t state;
	tw_mode_t mode;
	tw_code_t code;
	logic [4:0] raddr;
	logic [31:0] rdata;
	logic flag, flag_q, ack_en, sta, sto, wcol, en, stop_done, addr_phase, busy, to_stop;
	logic [1:0] ps, istat, imask;
	logic [7:0] wire_data_reg, own_addr, rate;
	logic [8:0] shifter;
	logic [3:0] bit_cnt;
	logic [15:0] tmr, half;
	logic wr_ctrl, wr_data, resume, is_master, col;
	// -------------------------
	// bus and pins
	// -------------------------
	tw_ahb u_ahb (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
		.hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
		.rdata_in(rdata), .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out),
		.hresp_out(hresp_out), .addr_out(raddr), .req_out(req)
	);
	tw_sync u_sync (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .scl_in(scl_in),
		.sda_in(sda_in), .line_out(line)
	);
	assign wr_ctrl = req.wr && (req.addr == `TW_OFF_CTRL);
	assign wr_data = req.wr && (req.addr == `TW_OFF_DATA);
	assign resume = wr_ctrl && req.wdata[`TW_CTRL_FLAG] && flag;
	assign col = wr_data && !flag;
	assign is_master = (mode == master_transmit_mode) || (mode == master_receive_mode);
	assign half = tw_half(rate, ps);
	// -------------------------
	// register reads
	// -------------------------
	always_comb begin
		rdata = 32'h0;
		case (raddr)
			`TW_OFF_CTRL: rdata[7:2] = {flag, ack_en, sta, sto, wcol, en};
			`TW_OFF_STAT: rdata[7:0] = {code, 1'b0, ps};
			`TW_OFF_DATA: rdata[7:0] = wire_data_reg;
			`TW_OFF_OWN: rdata[7:0] = own_addr;
			`TW_OFF_RATE: rdata[7:0] = rate;
			`TW_OFF_ISTAT: rdata[1:0] = istat;
			`TW_OFF_IMASK: rdata[1:0] = imask;
			default: rdata = 32'h0;
		endcase
	end
	// -------------------------
	// control registers
	// -------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			{ack_en, sta, sto, wcol, en} <= 5'h00;
			ps <= `TW_PS_RST;
			own_addr <= `TW_OWN_RST;
			rate <= `TW_RATE_RST;
			imask <= 2'h0;
		end else if (ce_in) begin
			if (stop_done) sto <= 1'b0;
			if (wr_ctrl) begin
				{ack_en, sta, sto} <= req.wdata[`TW_CTRL_ACK:`TW_CTRL_STO];
				en <= req.wdata[`TW_CTRL_EN];
			end
			if (req.wr && req.addr == `TW_OFF_STAT) ps <= req.wdata[1:0];
			if (req.wr && req.addr == `TW_OFF_OWN) own_addr <= req.wdata[7:0];
			if (req.wr && req.addr == `TW_OFF_RATE) rate <= req.wdata[7:0];
			if (req.wr && req.addr == `TW_OFF_IMASK) imask <= req.wdata[1:0];
			if (wr_data && flag) wcol <= 1'b0;
			if (col) wcol <= 1'b1;
		end
	end
	// -------------------------
	// interrupt
	// -------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			flag_q <= 1'b0;
			istat <= 2'h0;
			irq_out <= 1'b0;
		end else if (ce_in) begin
			flag_q <= flag;
			istat <= (istat & ~((req.wr && req.addr == `TW_OFF_ISTAT) ? req.wdata[1:0] : 2'h0))
				| {col, flag && !flag_q};
			irq_out <= |(istat & imask);
		end
	end
	// -------------------------
	// constant pin levels
	// -------------------------
	always_ff @(posedge clk_in) begin
		scl_out <= 1'b0;
		sda_out <= 1'b0;
	end
	// -------------------------
	// transfer engine
	// -------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= st_idle;
			mode <= mode_idle;
			code <= code_none;
			flag <= 1'b0;
			wire_data_reg <= `TW_DATA_RST;
			shifter <= 9'h1ff;
			bit_cnt <= 4'h0;
			tmr <= 16'h0;
			addr_phase <= 1'b0;
			busy <= 1'b0;
			to_stop <= 1'b0;
			stop_done <= 1'b0;
			scl_oe_n_out <= 1'b1;
			sda_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			stop_done <= 1'b0;
			if (tmr != 16'h0) tmr <= tmr - 16'h1;
			if (resume) flag <= 1'b0;
			if (wr_data && flag) wire_data_reg <= req.wdata[7:0];
			if (line.scl && line.sda_fall) busy <= 1'b1;
			if (line.scl && line.sda_rise) busy <= 1'b0;
			unique case (state)
				st_idle: begin
					scl_oe_n_out <= 1'b1;
					sda_oe_n_out <= 1'b1;
					if (en && sta && !busy && !flag) begin
						state <= st_start;
						sda_oe_n_out <= 1'b0;
						tmr <= half;
					end
				end
				st_start: if (tmr == 16'h0) begin
					scl_oe_n_out <= 1'b0;
					flag <= 1'b1;
					code <= (mode == mode_idle) ? code_start : code_rstart;
					mode <= master_transmit_mode;
					addr_phase <= 1'b1;
					state <= st_hold;
				end
				st_hold: if (resume) begin
					if (is_master) begin
						tmr <= half;
						if (req.wdata[`TW_CTRL_STO]) begin
							to_stop <= 1'b1;
							sda_oe_n_out <= 1'b0;
							state <= st_edge;
						end else if (req.wdata[`TW_CTRL_STA]) begin
							to_stop <= 1'b0;
							sda_oe_n_out <= 1'b1;
							state <= st_edge;
						end else begin
							bit_cnt <= 4'h0;
							state <= st_low;
							if (mode == master_receive_mode && !addr_phase)
								shifter <= {8'hff, ~req.wdata[`TW_CTRL_ACK]};
							else
								shifter <= {wire_data_reg, 1'b1};
						end
					end else if (code == code_sr_dnack || code == code_st_dnack) begin
						mode <= mode_idle;
						state <= st_idle;
					end else begin
						bit_cnt <= 4'h0;
						scl_oe_n_out <= 1'b1;
						state <= st_sl_bit;
						if (mode == slave_transmit_mode) begin
							shifter <= {wire_data_reg, 1'b1};
							sda_oe_n_out <= wire_data_reg[7];
						end else begin
							shifter <= 9'h1ff;
							sda_oe_n_out <= 1'b1;
						end
					end
				end
				st_edge: begin
					if (!scl_oe_n_out) begin
						if (tmr == 16'h0) begin
							scl_oe_n_out <= 1'b1;
							tmr <= half;
						end
					end else if (!line.scl) begin
						tmr <= half;
					end else if (tmr == 16'h0) begin
						tmr <= half;
						if (to_stop) begin
							sda_oe_n_out <= 1'b1;
							stop_done <= 1'b1;
							mode <= mode_idle;
							state <= st_idle;
						end else begin
							sda_oe_n_out <= 1'b0;
							state <= st_start;
						end
					end
				end
				st_low: begin
					sda_oe_n_out <= shifter[8];
					if (tmr == 16'h0) begin
						scl_oe_n_out <= 1'b1;
						tmr <= half;
						state <= st_high;
					end
				end
				st_high: if (!line.scl) begin
					tmr <= half;
				end else if (tmr == 16'h0) begin
					shifter <= {shifter[7:0], line.sda};
					tmr <= half;
					if (sda_oe_n_out && !line.sda && bit_cnt != 4'h8
						&& (addr_phase || mode == master_transmit_mode)) begin
						flag <= 1'b1;
						code <= code_lost;
						mode <= mode_idle;
						state <= st_idle;
					end else if (bit_cnt == 4'h8) begin
						scl_oe_n_out <= 1'b0;
						flag <= 1'b1;
						state <= st_hold;
						addr_phase <= 1'b0;
						if (addr_phase) begin
							if (shifter[0]) begin
								mode <= master_receive_mode;
								code <= line.sda ? code_ar_nack : code_ar_ack;
							end else begin
								mode <= master_transmit_mode;
								code <= line.sda ? code_aw_nack : addr_write_acked_code;
							end
						end else if (mode == master_transmit_mode) begin
							code <= line.sda ? code_mt_dnack : data_sent_acked_code;
						end else begin
							wire_data_reg <= shifter[7:0];
							code <= line.sda ? code_mr_dnack : code_mr_dack;
						end
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
						scl_oe_n_out <= 1'b0;
						state <= st_low;
					end
				end
				st_sl_bit: begin
					if (line.scl_rise) begin
						shifter <= {shifter[7:0], line.sda};
						bit_cnt <= bit_cnt + 4'h1;
					end
					if (line.scl_fall) begin
						if (bit_cnt == 4'h8) begin
							if (addr_phase)
								sda_oe_n_out <= shifter[7:1] != own_addr[7:1];
							else if (mode == slave_receive_mode)
								sda_oe_n_out <= ~ack_en;
							else
								sda_oe_n_out <= 1'b1;
						end else if (bit_cnt == 4'h9) begin
							sda_oe_n_out <= 1'b1;
							if (addr_phase && shifter[8:2] != own_addr[7:1]) begin
								mode <= mode_idle;
								state <= st_idle;
							end else begin
								scl_oe_n_out <= 1'b0;
								flag <= 1'b1;
								state <= st_hold;
								addr_phase <= 1'b0;
								if (addr_phase) begin
									mode <= shifter[1] ? slave_transmit_mode : slave_receive_mode;
									code <= shifter[1] ? code_st_addr : code_sr_addr;
								end else if (mode == slave_receive_mode) begin
									wire_data_reg <= shifter[8:1];
									code <= shifter[0] ? code_sr_dnack : code_sr_dack;
								end else begin
									code <= shifter[0] ? code_st_dnack : code_st_dack;
								end
							end
						end else begin
							sda_oe_n_out <= (mode == slave_transmit_mode && !addr_phase)
								? shifter[8] : 1'b1;
						end
					end
				end
			endcase
			if (en && line.scl && (state == st_idle || state == st_sl_bit)) begin
				if (line.sda_fall && ack_en) begin
					state <= st_sl_bit;
					bit_cnt <= 4'h0;
					shifter <= 9'h1ff;
					addr_phase <= 1'b1;
					sda_oe_n_out <= 1'b1;
				end else if (line.sda_rise && state == st_sl_bit) begin
					if (mode != mode_idle) begin
						flag <= 1'b1;
						code <= code_sl_stop;
					end
					mode <= mode_idle;
					state <= st_idle;
					sda_oe_n_out <= 1'b1;
				end
			end
			if (!en) begin
				state <= st_idle;
				mode <= mode_idle;
				scl_oe_n_out <= 1'b1;
				sda_oe_n_out <= 1'b1;
			end
		end
	end
	// -------------------------
	// checks
	// -------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence byte_end_s;
		ce_in && en && state == st_high && line.scl && tmr == 16'h0 && bit_cnt == 4'h8;
	endsequence
	sequence resume_s;
		ce_in && en && state == st_hold && resume && is_master;
	endsequence
	hold_suspend_a: assert property (state == st_hold |-> flag && !scl_oe_n_out)
		else $error("hold without flag or clock stretch");
	start_code_a: assert property (ce_in && en && state == st_start && tmr == 16'h0
		|=> flag && state == st_hold && (code == code_start || code == code_rstart))
		else $error("start not reported");
	byte_flag_a: assert property (byte_end_s |=> flag && state == st_hold)
		else $error("byte end without flag");
	mode_select_a: assert property (byte_end_s ##0 addr_phase
		|=> mode == ($past(shifter[0]) ? master_receive_mode : master_transmit_mode))
		else $error("wrong master mode after address");
	nack_code_a: assert property (byte_end_s ##0 (!addr_phase && mode == master_transmit_mode)
		|=> code == ($past(line.sda) ? code_mt_dnack : data_sent_acked_code))
		else $error("wrong data acknowledge code");
	collision_a: assert property (ce_in && col && state != st_high && state != st_sl_bit
		|=> wcol && $stable(wire_data_reg))
		else $error("collision not flagged");
	load_tx_a: assert property (resume_s ##0 (mode == master_transmit_mode
		&& !req.wdata[`TW_CTRL_STO] && !req.wdata[`TW_CTRL_STA])
		|=> state == st_low && shifter == {$past(wire_data_reg), 1'b1})
		else $error("byte not loaded on resume");
	stop_req_a: assert property (resume_s ##0 req.wdata[`TW_CTRL_STO]
		|=> state == st_edge && to_stop && !sda_oe_n_out)
		else $error("stop not started");
endmodule : tw_unit

// *** logic/tw_map.svh ***
`ifndef TW_MAP_SVH
`define TW_MAP_SVH
// -------------------------
// register offsets
// -------------------------
`define TW_OFF_CTRL 5'h00
`define TW_OFF_STAT 5'h04
`define TW_OFF_DATA 5'h08
`define TW_OFF_OWN 5'h0c
`define TW_OFF_RATE 5'h10
`define TW_OFF_ISTAT 5'h14
`define TW_OFF_IMASK 5'h18
// -------------------------
// field positions
// -------------------------
`define TW_CTRL_FLAG 7
`define TW_CTRL_ACK 6
`define TW_CTRL_STA 5
`define TW_CTRL_STO 4
`define TW_CTRL_WCOL 3
`define TW_CTRL_EN 2
`define TW_STAT_CODE 3
`define TW_IRQ_STEP 0
`define TW_IRQ_WCOL 1
// -------------------------
// reset values
// -------------------------
`define TW_RATE_RST 8'h0f
`define TW_OWN_RST 8'h00
`define TW_DATA_RST 8'hff
`define TW_PS_RST 2'h0
`endif

// *** logic/tw_pkg.sv ***
package tw_pkg;
	// status codes, stored without the three low bits
	typedef enum logic [4:0] {
		code_start = 5'h01,
		code_rstart = 5'h02,
		addr_write_acked_code = 5'h03,
		code_aw_nack = 5'h04,
		data_sent_acked_code = 5'h05,
		code_mt_dnack = 5'h06,
		code_lost = 5'h07,
		code_ar_ack = 5'h08,
		code_ar_nack = 5'h09,
		code_mr_dack = 5'h0a,
		code_mr_dnack = 5'h0b,
		code_sr_addr = 5'h0c,
		code_sr_dack = 5'h10,
		code_sr_dnack = 5'h11,
		code_sl_stop = 5'h14,
		code_st_addr = 5'h15,
		code_st_dack = 5'h17,
		code_st_dnack = 5'h18,
		code_none = 5'h1f
	} tw_code_t;
	typedef enum logic [2:0] {
		mode_idle,
		master_transmit_mode,
		master_receive_mode,
		slave_transmit_mode,
		slave_receive_mode
	} tw_mode_t;
	typedef struct packed {
		logic wr;
		logic [4:0] addr;
		logic [31:0] wdata;
	} tw_req_t;
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic sda_rise;
		logic sda_fall;
	} tw_line_t;
endpackage : tw_pkg

// *** logic/tw_sync.sv ***
`timescale 1ns/1ps
module tw_sync
	import tw_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output tw_line_t line_out
);
	logic [1:0] meta;
	logic [1:0] stable;
	logic [1:0] last;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta <= 2'h3;
			stable <= 2'h3;
			last <= 2'h3;
		end else if (ce_in) begin
			meta <= {scl_in, sda_in};
			stable <= meta;
			last <= stable;
		end
	end
	always_comb begin
		line_out.scl = stable[1];
		line_out.sda = stable[0];
		line_out.scl_rise = stable[1] & ~last[1];
		line_out.scl_fall = ~stable[1] & last[1];
		line_out.sda_rise = stable[0] & ~last[0];
		line_out.sda_fall = ~stable[0] & last[0];
	end
endmodule : tw_sync

// *** logic/tw_ahb.sv ***
`timescale 1ns/1ps
module tw_ahb
	import tw_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic [31:0] rdata_in,
	output logic hreadyout_out,
	output logic [31:0] hrdata_out,
	output logic hresp_out,
	output logic [4:0] addr_out,
	output tw_req_t req_out
);
	logic pend;
	logic pend_wr;
	logic pend_hit;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pend <= 1'b0;
			pend_wr <= 1'b0;
			pend_hit <= 1'b0;
			hreadyout_out <= 1'b1;
			hrdata_out <= 32'h0;
			hresp_out <= 1'b0;
			addr_out <= 5'h00;
			req_out <= '0;
		end else if (ce_in) begin
			req_out.wr <= 1'b0;
			if (pend) begin
				pend <= 1'b0;
				hreadyout_out <= 1'b1;
				req_out.wr <= pend_wr && pend_hit;
				req_out.addr <= addr_out;
				req_out.wdata <= hwdata_in;
				hrdata_out <= (pend_hit && !pend_wr) ? rdata_in : 32'h0;
			end else if (hsel_in && htrans_in[1] && hready_in) begin
				pend <= 1'b1;
				hreadyout_out <= 1'b0;
				addr_out <= haddr_in[4:0];
				pend_wr <= hwrite_in && (hsize_in == 3'h2);
				pend_hit <= (haddr_in[31:5] == 27'h0) && (haddr_in[1:0] == 2'h0);
			end
		end
	end
endmodule : tw_ahb

// *** tb/tw_slave_model.sv ***
`timescale 1ns/1ps
// ----------
// two-wire slave partner
// ----------
module tw_slave_model #(
	parameter logic [6:0] SLV_ADDR = 7'h2a
) (
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic nack_in,
	input wire logic [7:0] tx_in,
	output logic sda_oe_n_out,
	output logic [7:0] rx_out,
	output int rx_cnt_out
);
	task automatic get_byte(output logic [7:0] b);
		repeat (8) begin
			@(posedge scl_in);
			b = {b[6:0], sda_in};
		end
	endtask : get_byte

	task automatic ack_slot;
		@(negedge scl_in);
		sda_oe_n_out = 1'b0;
		@(negedge scl_in);
		sda_oe_n_out = 1'b1;
	endtask : ack_slot

	task automatic frame;
		logic [7:0] b;
		logic rd;
		get_byte(b);
		if (b[7:1] != SLV_ADDR || nack_in) return;
		rd = b[0];
		ack_slot();
		forever begin
			if (rd) begin
				for (int i = 7; i >= 0; i--) begin
					sda_oe_n_out = tx_in[i];
					@(negedge scl_in);
				end
				sda_oe_n_out = 1'b1;
				@(posedge scl_in);
				if (sda_in) return;
				@(negedge scl_in);
			end else begin
				get_byte(b);
				rx_out = b;
				rx_cnt_out++;
				if (nack_in) return;
				ack_slot();
			end
		end
	endtask : frame

	initial begin
		sda_oe_n_out = 1'b1;
		rx_out = 8'h00;
		rx_cnt_out = 0;
		forever begin
			@(negedge sda_in iff scl_in === 1'b1);
			fork : run
				frame();
				@(posedge sda_in iff scl_in === 1'b1);
			join_any
			disable run;
			sda_oe_n_out = 1'b1;
		end
	end
endmodule : tw_slave_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "tw_map.svh"
module testbench
	import tw_pkg::*;
;
	localparam logic [6:0] SLV = 7'h2a;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic hsel, hwrite, hreadyout, hresp, scl_out, scl_oe_n, sda_out, sda_oe_n, irq, nack;
	logic m_sda_oe_n;
	logic mst_scl_oe_n = 1'b1;
	logic mst_sda_oe_n = 1'b1;
	logic ack_a, ack_d, ack_p;
	logic [31:0] haddr, hwdata, hrdata, rdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] tx, rx;
	int rx_cnt;
	int n_errors = 0;
	int num_checks = 0;
	logic [31:0] s = 32'heabb205b;
	logic [63:0] rd_q[$];
	logic [7:0] rx_q[$];
	event rd_ev;
	wire logic scl_w = scl_oe_n & mst_scl_oe_n;
	wire logic sda_w = sda_oe_n & m_sda_oe_n & mst_sda_oe_n;

	always #20 clk_in = ~clk_in;

	tw_unit u_tw_unit (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
		.hrdata_out(hrdata), .hresp_out(hresp), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe_n_out(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_n_out(sda_oe_n), .irq_out(irq));

	tw_slave_model #(.SLV_ADDR(SLV)) u_tw_slave_model (.scl_in(scl_w), .sda_in(sda_w),
		.nack_in(nack), .tx_in(tx), .sda_oe_n_out(m_sda_oe_n), .rx_out(rx),
		.rx_cnt_out(rx_cnt));

	// ----------
	// helpers
	// ----------
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {27'h0, a};
		hwrite <= w;
		@(posedge clk_in);
		while (hreadyout !== 1'b1) @(posedge clk_in);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk_in);
		while (hreadyout !== 1'b1) @(posedge clk_in);
		rdata = hrdata;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		rd_q.push_back({m, e});
		bus(1'b0, a, 32'h0);
		->rd_ev;
	endtask : rd

	task automatic wait_irq;
		int i;
		for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk_in);
	endtask : wait_irq

	task automatic look(input tw_code_t code);
		wait_irq();
		rd(`TW_OFF_CTRL, 32'h80, 32'h80);
		check("clock held low", 32'h0, {31'h0, scl_oe_n});
		rd(`TW_OFF_STAT, 32'hf8, {24'h0, code, 3'h0});
		wr(`TW_OFF_ISTAT, 32'h1);
	endtask : look

	task automatic step(input logic [7:0] c, input tw_code_t code);
		wr(`TW_OFF_CTRL, {24'h0, c});
		look(code);
	endtask : step

	// bench as bus master, one bit of 320 ns, waits while the clock is stretched
	task automatic mst_bit(input logic b, input logic last, output logic got);
		int i;
		@(posedge clk_in);
		mst_sda_oe_n <= b;
		repeat (3) @(posedge clk_in);
		mst_scl_oe_n <= 1'b1;
		@(posedge clk_in);
		for (i = 0; i < 3000 && scl_w !== 1'b1; i++) @(posedge clk_in);
		repeat (3) @(posedge clk_in);
		got = sda_w;
		if (last) begin
			mst_sda_oe_n <= 1'b1;
		end else begin
			mst_scl_oe_n <= 1'b0;
		end
	endtask : mst_bit

	task automatic mst_byte(input logic [7:0] d, output logic ack);
		logic g;
		for (int k = 7; k >= 0; k--) begin
			mst_bit(d[k], 1'b0, g);
		end
		mst_bit(1'b1, 1'b0, ack);
	endtask : mst_byte

	task automatic mst_start;
		mst_sda_oe_n <= 1'b0;
		repeat (4) @(posedge clk_in);
		mst_scl_oe_n <= 1'b0;
	endtask : mst_start

	task automatic stop_bus;
		int i;
		wr(`TW_OFF_CTRL, 32'h94);
		rdata = 32'h10;
		for (i = 0; i < 300 && rdata[`TW_CTRL_STO] !== 1'b0; i++) bus(1'b0, `TW_OFF_CTRL, 32'h0);
		rd(`TW_OFF_CTRL, 32'h90, 32'h0);
		check("data line idle", 32'h1, {31'h0, sda_w});
		check("irq after stop", 32'h0, {31'h0, irq});
		check("fixed outputs", 32'h0, {29'h0, hresp, scl_out, sda_out});
	endtask : stop_bus

	always @(rd_ev) begin
		logic [63:0] e;
		e = rd_q.pop_front();
		check("read data", e[31:0], rdata & e[63:32]);
	end

	always @(rx_cnt) begin
		if (rx_cnt != 0) begin
			check("slave byte", {24'h0, rx_q.pop_front()}, {24'h0, rx});
		end
	end

	initial begin
		repeat (60000) @(posedge clk_in);
		n_errors++;
		end_sim();
	end

	// ----------
	// scenarios
	// ----------
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		nack = 1'b0;
		tx = 8'h00;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		rd(`TW_OFF_STAT, 32'hff, 32'hf8);
		wr(`TW_OFF_STAT, 32'h1);
		rd(`TW_OFF_STAT, 32'hff, 32'hf9);
		wr(`TW_OFF_STAT, 32'h0);
		wr(`TW_OFF_RATE, 32'h1);
		wr(`TW_OFF_IMASK, 32'h2);
		wr(`TW_OFF_DATA, 32'h55);
		rd(`TW_OFF_DATA, 32'hff, 32'hff);
		rd(`TW_OFF_CTRL, 32'h08, 32'h08);
		rd(`TW_OFF_ISTAT, 32'hff, 32'h02);
		check("irq raised", 32'h1, {31'h0, irq});
		wr(`TW_OFF_IMASK, 32'h1);
		repeat (2) @(posedge clk_in);
		check("irq masked", 32'h0, {31'h0, irq});
		wr(`TW_OFF_ISTAT, 32'h2);
		rd(`TW_OFF_ISTAT, 32'hff, 32'h0);
		// master write, two random bytes
		step(8'ha4, code_start);
		wr(`TW_OFF_DATA, {24'h0, SLV, 1'b0});
		rd(`TW_OFF_CTRL, 32'h08, 32'h0);
		step(8'h84, addr_write_acked_code);
		repeat (2) begin
			s = lfsr(s);
			rx_q.push_back(s[7:0]);
			wr(`TW_OFF_DATA, {24'h0, s[7:0]});
			step(8'h84, data_sent_acked_code);
		end
		stop_bus();
		// master read, byte refused by master
		s = lfsr(s);
		tx <= s[15:8];
		step(8'ha4, code_start);
		wr(`TW_OFF_DATA, {24'h0, SLV, 1'b1});
		step(8'h84, code_ar_ack);
		step(8'h84, code_mr_dnack);
		rd(`TW_OFF_DATA, 32'hff, {24'h0, s[15:8]});
		stop_bus();
		// address refused by slave
		nack <= 1'b1;
		step(8'ha4, code_start);
		wr(`TW_OFF_DATA, {24'h0, SLV, 1'b0});
		step(8'h84, code_aw_nack);
		stop_bus();
		// slave receive, bench drives the bus
		s = lfsr(s);
		wr(`TW_OFF_OWN, {24'h0, 7'h31, 1'b0});
		wr(`TW_OFF_CTRL, 32'h44);
		fork
			begin
				mst_start();
				mst_byte({7'h31, 1'b0}, ack_a);
				mst_byte(s[7:0], ack_d);
				mst_bit(1'b0, 1'b1, ack_p);
			end
			begin
				look(code_sr_addr);
				step(8'hc4, code_sr_dack);
				wr(`TW_OFF_CTRL, 32'hc4);
				wait_irq();
				rd(`TW_OFF_STAT, 32'hf8, {24'h0, code_sl_stop, 3'h0});
				check("clock released", 32'h1, {31'h0, scl_oe_n});
			end
		join
		check("slave acks", 32'h0, {30'h0, ack_a, ack_d});
		rd(`TW_OFF_DATA, 32'hff, {24'h0, s[7:0]});
		check("bytes pending", 32'h0, rx_q.size());
		end_sim();
	end
endmodule : testbench
